//--- hw/twm_master.sv
// Two-wire serial master: hardware-sequenced transfers over open-drain clock and data
`timescale 1ns/100ps
module twm_master
    import twm_pkg::*;
(
    input wire logic clock,
    input wire logic rst_n,
    input wire logic start,
    input wire twm_cmd_type cmd,
    output logic busy,
    input wire logic wr_valid,
    input wire logic [7:0] wr_data,
    output logic wr_ready,
    output logic [7:0] rd_data,
    output logic rd_valid,
    output logic done,
    output twm_status_type status,
    input wire logic scl_i,
    output logic scl_o,
    output logic scl_oe,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe
);
    typedef enum logic [3:0] {
        ST_IDLE,
        ST_START,
        ST_ADDR,
        ST_WBYTE,
        ST_RBYTE,
        ST_WAIT_DATA,
        ST_STOP,
        ST_DONE
    } twm_state_type;

    // ****************************************
    // Registers
    // ****************************************
    twm_state_type state_ff;
    twm_cmd_type cmd_ff;
    logic [7:0] qtr_cnt_ff;
    logic [1:0] phase_ff;
    logic [3:0] bit_ff;
    logic [8:0] shift_ff;
    logic [CNT_W-1:0] wr_left_ff;
    logic [CNT_W-1:0] rd_left_ff;
    logic second_ff;
    logic scl_low_ff;
    logic sda_low_ff;
    logic nack_ff;
    logic [CNT_W-1:0] rd_cnt_ff;
    logic [7:0] rd_data_ff;
    logic rd_valid_ff;
    logic done_ff;
    logic [2:0] sda_sync_ff;
    logic sda_in_ff;

    // ****************************************
    // Decoding
    // ****************************************
    // Rate picks the quarter-bit length; the 800k and 1M entries run with no slave guarantee
    // While idle the incoming command picks the rate, so the very first quarter runs at speed
    wire [1:0] rate_sel = (state_ff == ST_IDLE) ? cmd.rate : cmd_ff.rate;
    wire [7:0] qtr_len = (rate_sel == TWM_RATE_100K) ? QTR_100K :
                         (rate_sel == TWM_RATE_400K) ? QTR_400K :
                         (rate_sel == TWM_RATE_800K) ? QTR_800K : QTR_1M;
    wire tick = (qtr_cnt_ff == 8'h01);
    wire bit_end = tick && (phase_ff == 2'h3);
    // First phase reads when the shape starts with a read
    wire first_is_read = (cmd_ff.kind == TWM_XFER_READ) || (cmd_ff.kind == TWM_XFER_READ_WRITE);
    wire combined = (cmd_ff.kind == TWM_XFER_READ_WRITE) || (cmd_ff.kind == TWM_XFER_WRITE_READ);
    wire cur_read = first_is_read ^ second_ff;
    wire more_rd = (rd_left_ff != '0);
    wire more_wr = (wr_left_ff != '0);
    wire last_rd = (rd_left_ff == CNT_W'(1));
    // Data line sample point is mid-high of the clock
    wire sample_pt = tick && (phase_ff == 2'h2);

    // Handshake outputs
    assign busy = (state_ff != ST_IDLE);
    assign wr_ready = (state_ff == ST_WAIT_DATA);
    // Open drain: only ever drive low, release otherwise
    assign scl_o = 1'b0;
    assign sda_o = 1'b0;
    assign scl_oe = scl_low_ff;
    assign sda_oe = sda_low_ff;
    assign rd_data = rd_data_ff;
    assign rd_valid = rd_valid_ff;
    assign done = done_ff;
    assign status = '{nack: nack_ff, rd_count: rd_cnt_ff};

    // ****************************************
    // Input synchroniser
    // ****************************************
    // Data pin is outside our domain; take it once stages two and three agree
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            sda_sync_ff <= 3'h7;
            sda_in_ff <= 1'b1;
        end else begin
            sda_sync_ff <= {sda_sync_ff[1:0], sda_i};
            if (sda_sync_ff[1] == sda_sync_ff[2]) begin
                sda_in_ff <= sda_sync_ff[2];
            end
        end
    end

    // ****************************************
    // Quarter-bit divider
    // ****************************************
    // Free count of the bus clock; scl_i is never read, so stretching is not honoured
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            qtr_cnt_ff <= 8'h01;
            phase_ff <= 2'h0;
        end else if (state_ff == ST_IDLE || state_ff == ST_WAIT_DATA) begin
            qtr_cnt_ff <= qtr_len;
            phase_ff <= 2'h0;
        end else if (tick) begin
            qtr_cnt_ff <= qtr_len;
            phase_ff <= phase_ff + 2'h1;
        end else begin
            qtr_cnt_ff <= qtr_cnt_ff - 8'h01;
        end
    end

    // ****************************************
    // Sequencer
    // ****************************************
    // One strobe starts the job; the rest runs bit by bit in hardware.
    // Single master: line levels are never compared against what we drive.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            state_ff <= ST_IDLE;
            cmd_ff <= '0;
            bit_ff <= 4'h0;
            shift_ff <= 9'h1ff;
            wr_left_ff <= '0;
            rd_left_ff <= '0;
            second_ff <= 1'b0;
            scl_low_ff <= 1'b0;
            sda_low_ff <= 1'b0;
            nack_ff <= 1'b0;
            rd_cnt_ff <= '0;
            rd_data_ff <= 8'h00;
            rd_valid_ff <= 1'b0;
            done_ff <= 1'b0;
        end else begin
            rd_valid_ff <= 1'b0;
            done_ff <= 1'b0;
            case (state_ff)
                ST_IDLE: begin
                    scl_low_ff <= 1'b0;
                    sda_low_ff <= 1'b0;
                    if (start) begin
                        cmd_ff <= cmd;
                        // Lengths clipped to sixteen per direction
                        wr_left_ff <= (cmd.wr_len > CNT_W'(MAX_BYTES)) ? CNT_W'(MAX_BYTES) : cmd.wr_len;
                        rd_left_ff <= (cmd.rd_len > CNT_W'(MAX_BYTES)) ? CNT_W'(MAX_BYTES) : cmd.rd_len;
                        second_ff <= 1'b0;
                        nack_ff <= 1'b0;
                        rd_cnt_ff <= '0;
                        state_ff <= ST_START;
                    end
                end
                ST_START: begin
                    // Phases: 0 release data, 1 raise clock, 2 pull data (start), 3 pull clock
                    if (tick) begin
                        case (phase_ff)
                            2'h0: sda_low_ff <= 1'b0;
                            2'h1: scl_low_ff <= 1'b0;
                            2'h2: sda_low_ff <= 1'b1;
                            default: scl_low_ff <= 1'b1;
                        endcase
                    end
                    if (bit_end) begin
                        // Address plus direction, ninth bit released for the acknowledge
                        shift_ff <= {cmd_ff.addr, (cur_read ? DIR_READ : DIR_WRITE), 1'b1};
                        bit_ff <= 4'h0;
                        state_ff <= ST_ADDR;
                    end
                end
                ST_ADDR, ST_WBYTE, ST_RBYTE: begin
                    // Clock low in phases 0 and 1, high in 2 and 3; data moves a quarter
                    // before the clock rises, so it never changes on the rising edge
                    if (tick) begin
                        case (phase_ff)
                            2'h0: sda_low_ff <= ~shift_ff[8];
                            2'h1: scl_low_ff <= 1'b0;
                            2'h3: scl_low_ff <= 1'b1;
                            default: scl_low_ff <= scl_low_ff;
                        endcase
                    end
                    if (sample_pt) begin
                        if (bit_ff == 4'h8) begin
                            // Acknowledge slot: a high line on our own receive is fine
                            if (state_ff != ST_RBYTE && sda_in_ff) begin
                                nack_ff <= 1'b1;
                            end
                        end else if (state_ff == ST_RBYTE) begin
                            rd_data_ff <= {rd_data_ff[6:0], sda_in_ff};
                        end
                    end
                    if (bit_end) begin
                        shift_ff <= {shift_ff[7:0], 1'b1};
                        bit_ff <= bit_ff + 4'h1;
                        if (bit_ff == 4'h7 && state_ff == ST_RBYTE) begin
                            // Ack every byte but the last of the read phase
                            shift_ff <= {last_rd, 8'hff};
                            rd_valid_ff <= 1'b1;
                            rd_cnt_ff <= rd_cnt_ff + CNT_W'(1);
                            rd_left_ff <= rd_left_ff - CNT_W'(1);
                        end
                        if (bit_ff == 4'h8) begin
                            bit_ff <= 4'h0;
                            if (nack_ff) begin
                                state_ff <= ST_STOP;
                            end else if (cur_read && more_rd) begin
                                shift_ff <= 9'h1ff;
                                state_ff <= ST_RBYTE;
                            end else if (!cur_read && more_wr) begin
                                state_ff <= ST_WAIT_DATA;
                            end else if (combined && !second_ff) begin
                                second_ff <= 1'b1;
                                state_ff <= ST_START;
                            end else begin
                                state_ff <= ST_STOP;
                            end
                        end
                    end
                end
                ST_WAIT_DATA: begin
                    // Clock held low while the source catches up
                    if (wr_valid) begin
                        shift_ff <= {wr_data, 1'b1};
                        wr_left_ff <= wr_left_ff - CNT_W'(1);
                        state_ff <= ST_WBYTE;
                    end
                end
                ST_STOP: begin
                    // Phases: 0 pull data, 1 release clock, 2 release data (stop)
                    if (tick) begin
                        case (phase_ff)
                            2'h0: sda_low_ff <= 1'b1;
                            2'h1: scl_low_ff <= 1'b0;
                            2'h2: sda_low_ff <= 1'b0;
                            default: sda_low_ff <= 1'b0;
                        endcase
                    end
                    if (bit_end) begin
                        state_ff <= ST_DONE;
                    end
                end
                ST_DONE: begin
                    done_ff <= 1'b1;
                    state_ff <= ST_IDLE;
                end
                default: state_ff <= ST_IDLE;
            endcase
        end
    end
endmodule : twm_master

//--- hw/twm_pkg.sv
// Package: constants and carrier types for the two-wire master controller
package twm_pkg;
    // ****************************************
    // Clocking
    // ****************************************
    localparam int CLK_HZ = 100000000;
    localparam int RATE_100K_HZ = 100000;
    localparam int RATE_400K_HZ = 400000;
    localparam int RATE_800K_HZ = 800000;
    localparam int RATE_1M_HZ = 1000000;
    // Quarter-bit tick counts, rounded down so the bus never runs slower than asked
    localparam logic [7:0] QTR_100K = 8'(CLK_HZ / (RATE_100K_HZ * 4));
    localparam logic [7:0] QTR_400K = 8'(CLK_HZ / (RATE_400K_HZ * 4));
    localparam logic [7:0] QTR_800K = 8'(CLK_HZ / (RATE_800K_HZ * 4));
    localparam logic [7:0] QTR_1M = 8'(CLK_HZ / (RATE_1M_HZ * 4));

    // ****************************************
    // Transfer shapes and limits
    // ****************************************
    localparam int MAX_BYTES = 16;
    localparam int CNT_W = 5;
    localparam logic [0:0] DIR_WRITE = 1'b0;
    localparam logic [0:0] DIR_READ = 1'b1;

    typedef enum logic [1:0] {
        TWM_RATE_100K,
        TWM_RATE_400K,
        TWM_RATE_800K,
        TWM_RATE_1M
    } twm_rate_type;

    typedef enum logic [1:0] {
        TWM_XFER_READ,
        TWM_XFER_WRITE,
        TWM_XFER_READ_WRITE,
        TWM_XFER_WRITE_READ
    } twm_xfer_type;

    // Job handed in by firmware with a start strobe
    typedef struct packed {
        logic [6:0] addr;
        twm_xfer_type kind;
        twm_rate_type rate;
        logic [CNT_W-1:0] wr_len;
        logic [CNT_W-1:0] rd_len;
    } twm_cmd_type;

    // Outcome reported on completion
    typedef struct packed {
        logic nack;
        logic [CNT_W-1:0] rd_count;
    } twm_status_type;
endpackage : twm_pkg

//--- testbench/twm_master_asserts.sv
// Checker: port-level properties of the two-wire master
`timescale 1ns/100ps
module twm_master_asserts
    import twm_pkg::*;
(
    input wire logic clock,
    input wire logic rst_n,
    input wire logic start,
    input wire logic busy,
    input wire logic wr_ready,
    input wire logic rd_valid,
    input wire logic done,
    input wire twm_status_type status,
    input wire logic scl_o,
    input wire logic scl_oe,
    input wire logic sda_o,
    input wire logic sda_oe
);
    // ********
    // Properties
    // ********
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);

    a_idle_released: assert property (!busy |-> !scl_oe && !sda_oe)
        else $error("line pulled while idle");
    a_pull_low_only: assert property ((scl_oe || sda_oe) |-> !(scl_oe && scl_o) && !(sda_oe && sda_o))
        else $error("line driven high");
    a_start_taken: assert property (start && !busy |=> busy)
        else $error("start not taken");
    a_done_single: assert property (done |=> !done)
        else $error("done longer than one cycle");
    a_done_to_idle: assert property (done |-> ##[0:2] !busy)
        else $error("busy after done");
    a_busy_ends_done: assert property ($fell(busy) |-> done || $past(done) || $past(done, 2))
        else $error("transfer ended without done");
    a_read_pulse: assert property (rd_valid |=> !rd_valid [*8])
        else $error("read strobe too long");
    a_read_in_xfer: assert property (rd_valid |-> busy)
        else $error("read byte outside a transfer");
    a_wait_clock_low: assert property (wr_ready |-> scl_oe)
        else $error("clock released while waiting for data");
    a_status_hold: assert property (!busy && !start |=> $stable(status))
        else $error("status moved while idle");
    a_count_limit: assert property (done |-> status.rd_count <= 5'h10)
        else $error("read count above sixteen");
endmodule : twm_master_asserts

bind twm_master twm_master_asserts u_chk (.clock(clock), .rst_n(rst_n), .start(start),
    .busy(busy), .wr_ready(wr_ready), .rd_valid(rd_valid), .done(done), .status(status),
    .scl_o(scl_o), .scl_oe(scl_oe), .sda_o(sda_o), .sda_oe(sda_oe));

//--- testbench/twm_slave_model.sv
// Partner: behavioural two-wire slave answering at one address
`timescale 1ns/100ps
module twm_slave_model #(
    parameter logic [6:0] ADDR = 7'h2a
) (
    input wire logic scl,
    input wire logic sda,
    input wire logic [7:0] base,
    output logic pull
);
    logic [7:0] sh;
    logic [7:0] tx;
    logic act = 1'b0;
    logic adr = 1'b0;
    logic rdd = 1'b0;
    int bitn = 0;
    int starts = 0;
    logic [7:0] rx_q[$];
    // Only pulls data low; the clock line is never held, so no stretching
    initial pull = 1'b0;
    // Start or repeated start: data falls while clock is high
    always @(negedge sda) begin
        if (scl === 1'b1) begin
            act = 1'b1;
            adr = 1'b1;
            rdd = 1'b0;
            bitn = 0;
            pull = 1'b0;
            tx = base;
            starts++;
        end
    end
    // Stop: data rises while clock is high
    always @(posedge sda) begin
        if (scl === 1'b1) act = 1'b0;
    end
    // Sample on the rising clock; a master nack ends the read
    always @(posedge scl) begin
        if (act) begin
            if (bitn < 8) sh = {sh[6:0], sda};
            else if (rdd && !pull) begin
                if (sda) act = 1'b0;
                else tx = tx + 8'h01;
            end
            bitn++;
        end
    end
    // Drive on the falling clock: acks, then read data MSB first
    always @(negedge scl) begin
        if (act) begin
            if (bitn == 8 && !rdd) begin
                if (adr) begin
                    act = sh[7:1] == ADDR;
                    rdd = sh[0] & act;
                    adr = 1'b0;
                end else rx_q.push_back(sh);
                pull = act;
            end else begin
                if (bitn == 9) bitn = 0;
                pull = rdd && bitn < 8 && !tx[7-bitn];
            end
        end
    end
endmodule : twm_slave_model

//--- testbench/testbench.sv
// Testbench: transfers of every shape and rate against the slave model
`timescale 1ns/100ps
module testbench
    import twm_pkg::*;
;
    localparam logic [6:0] SLV = 7'h2a;
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic start = 1'b0;
    twm_cmd_type cmd = '0;
    logic wr_valid = 1'b0;
    logic [7:0] wr_data = 8'h00;
    logic busy, wr_ready, rd_valid, done, scl_o, scl_oe, sda_o, sda_oe, pull;
    logic take = 1'b0;
    logic [7:0] rd_data;
    logic [7:0] base = 8'h00;
    twm_status_type status;
    // Pull-ups: a released line reads high
    wire logic scl = scl_oe ? scl_o : 1'b1;
    wire logic sda = (sda_oe ? sda_o : 1'b1) & !pull;
    int err_total = 0;
    int total_checks = 0;
    int starts = 0;
    logic [7:0] wq[$];
    logic [7:0] wexp[$];
    logic [7:0] rexp[$];
    twm_status_type sq[$];
    int nq[$];

    always #5 clock = ~clock;

    twm_master DUT (.clock(clock), .rst_n(rst_n), .start(start), .cmd(cmd), .busy(busy),
        .wr_valid(wr_valid), .wr_data(wr_data), .wr_ready(wr_ready), .rd_data(rd_data),
        .rd_valid(rd_valid), .done(done), .status(status), .scl_i(scl), .scl_o(scl_o),
        .scl_oe(scl_oe), .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe));
    twm_slave_model #(.ADDR(SLV)) slave (.scl(scl), .sda(sda), .base(base), .pull(pull));

    // ********
    // Checking and closing
    // ********
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    task automatic summarize;
        $display("Checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : summarize

    // Byte source: a byte stays offered until taken; random stalls between bytes
    always @(negedge clock) take = wr_valid && wr_ready;
    always @(posedge clock) begin
        if (take) void'(wq.pop_front());
        wr_valid <= wq.size() != 0 && ((wr_valid && !take) || $urandom_range(1) == 1);
        wr_data <= wq.size() != 0 ? wq[0] : 8'h00;
    end

    // Watcher: each result takes the oldest note off its queue
    always @(negedge clock) begin
        if (rd_valid === 1'b1) chk("read byte", rd_data, rexp.pop_front());
        if (done === 1'b1) begin
            chk("nack", status.nack, sq[0].nack);
            chk("read count", status.rd_count, sq[0].rd_count);
            chk("starts", slave.starts, nq.pop_front());
            void'(sq.pop_front());
            while (wexp.size() != 0) chk("written", slave.rx_q.pop_front(), wexp.pop_front());
            chk("extra written", slave.rx_q.size(), 0);
        end
    end

    // One transfer: note the results, fire it, poke a stray start, wait for the end
    task automatic run(input logic [6:0] a, input twm_xfer_type k, input twm_rate_type r,
                       input int wn, input int rn);
        logic ok;
        logic [7:0] b;
        logic [31:0] per;
        realtime t0;
        int n;
        ok = a == SLV;
        base = 8'($urandom);
        for (n = 0; n < wn && k != TWM_XFER_READ && ok; n++) begin
            b = 8'($urandom);
            wq.push_back(b);
            wexp.push_back(b);
        end
        for (n = 0; n < rn && k != TWM_XFER_WRITE && ok; n++) rexp.push_back(8'(base + n));
        sq.push_back('{nack: !ok, rd_count: (ok && k != TWM_XFER_WRITE) ? CNT_W'(rn) : '0});
        starts += (ok && (k == TWM_XFER_READ_WRITE || k == TWM_XFER_WRITE_READ)) ? 2 : 1;
        nq.push_back(starts);
        per = 40 * ((r == TWM_RATE_100K) ? QTR_100K : (r == TWM_RATE_400K) ? QTR_400K :
                    (r == TWM_RATE_800K) ? QTR_800K : QTR_1M);
        @(posedge clock);
        start <= 1'b1;
        cmd <= '{addr: a, kind: k, rate: r, wr_len: CNT_W'(wn), rd_len: CNT_W'(rn)};
        @(posedge clock);
        start <= 1'b0;
        @(negedge clock);
        chk("busy after start", busy, 1'b1);
        @(posedge scl);
        @(posedge scl);
        t0 = $realtime;
        @(posedge scl);
        chk("bit period ns", 32'($rtoi($realtime - t0)), per);
        @(posedge clock);
        start <= 1'b1;
        @(posedge clock);
        start <= 1'b0;
        n = 0;
        while (busy !== 1'b0 && n < 40000) begin
            @(negedge clock);
            n++;
        end
        chk("finished in time", n < 40000, 1'b1);
        repeat (3) @(negedge clock);
        $display("Transfer kind %0d rate %0d finished", k, r);
    endtask : run

    // Main sequence: every rate, every shape, the 16-byte edge, a refused address
    initial begin
        void'($urandom(40));
        repeat (10) @(posedge clock);
        rst_n <= 1'b1;
        for (int i = 0; i < 4; i++) run(SLV, TWM_XFER_WRITE, twm_rate_type'(i), 1, 0);
        run(SLV, TWM_XFER_READ, TWM_RATE_400K, 0, 3);
        run(SLV, TWM_XFER_READ_WRITE, TWM_RATE_1M, 16, 2);
        run(SLV, TWM_XFER_WRITE_READ, TWM_RATE_800K, 1, 16);
        run(7'h15, TWM_XFER_WRITE, TWM_RATE_1M, 2, 0);
        summarize();
    end

    // Watchdog: tests need about 80k cycles; limit keeps the run below 100k
    initial begin
        #950000;
        err_total++;
        $display("Watchdog expired");
        summarize();
    end
endmodule : testbench
